// ==== design/stm_supply_monitor.sv ====
// supply threshold monitor: apb registers, status, low supply event, interrupt
//
// How it works
// - control bit 5 reads one while the supply is above the selected threshold.
// - status always compares against the currently held range and code settings.
// - control bit 4 is read-write range select, zero low, one high.
// - control bits 3:0 hold a read-write four bit threshold code.
// - high range codes map linearly from 2.550 V up to 3.675 V.
// - low range codes map linearly from 1.70 V up to 2.45 V.
// - reset selects 1.8 V, code two with the low range.
// - a status fall from one to zero raises the low supply event.
// - no event while status stays zero, even after reprogramming.
// - in deepest power-down status holds and no events are raised.
`timescale 1ns/1ps
module stm_supply_monitor
  import stm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analogue comparator on the external supply pin
  input wire logic cmp_above_raw,
  output logic [3:0] threshold_code,
  output logic threshold_high_range,
  output logic [11:0] threshold_mv,
  output logic monitor_enable,
  // power state from the device state machine
  input wire logic deep_sleep,
  // interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // internal signals
  // ---------------------------------------------------------------
  logic cmp_above_sync;
  logic enable_seen;
  logic cmp_settled;
  logic supply_above_threshold;
  logic [0:0] irq_status;
  logic [0:0] irq_mask;
  logic low_supply_event;
  logic [11:0] next_threshold_mv;
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic hit_ctrl;
  logic hit_status;
  logic hit_mask;
  logic mapped;
  logic [31:0] next_prdata;

  // ---------------------------------------------------------------
  // comparator synchroniser
  // ---------------------------------------------------------------
  // the comparator output is asynchronous to pclk
  stm_sync2 #(
    .W(1)
  ) u_cmp_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(cmp_above_raw),
    .sync_out(cmp_above_sync)
  );

  // ---------------------------------------------------------------
  // threshold ladder
  // ---------------------------------------------------------------
  stm_threshold_decode u_decode (
    .threshold_code(threshold_code),
    .threshold_high_range(threshold_high_range),
    .threshold_mv(next_threshold_mv)
  );

  // threshold value to the comparator, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      threshold_mv <= STM_LOW_BASE_MV + STM_LOW_STEP_MV + STM_LOW_STEP_MV;
    end else begin
      threshold_mv <= next_threshold_mv;
    end
  end

  // comparator powered only outside deepest power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_enable <= 1'b0;
    end else begin
      monitor_enable <= !deep_sleep;
    end
  end

  // a synchronised sample counts only if the comparator was powered when it was
  // taken, so a wake-up does not read the powered-down level as a supply fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_seen <= 1'b0;
      cmp_settled <= 1'b0;
    end else begin
      enable_seen <= monitor_enable;
      cmp_settled <= enable_seen;
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_access = access_phase && pwrite;
  assign hit_ctrl = (paddr == STM_ADDR_CTRL);
  assign hit_status = (paddr == STM_ADDR_IRQ_STATUS);
  assign hit_mask = (paddr == STM_ADDR_IRQ_MASK);
  assign mapped = hit_ctrl || hit_status || hit_mask;
  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_phase && !mapped;

  // ---------------------------------------------------------------
  // control register: range select and threshold code
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      threshold_code <= STM_CODE_RST;
      threshold_high_range <= STM_RANGE_RST;
    end else if (wr_access && hit_ctrl) begin
      threshold_code <= pwdata[STM_CODE_LSB +: STM_CODE_W];
      threshold_high_range <= pwdata[STM_RANGE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // supply status
  // ---------------------------------------------------------------
  // the comparator always sees the current threshold, so the
  // synchronised level is the live verdict; frozen while asleep and
  // until the first sample of a powered comparator arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_above_threshold <= STM_STATUS_RST;
    end else if (!deep_sleep && cmp_settled) begin
      supply_above_threshold <= cmp_above_sync;
    end
  end

  // a one-to-zero step of the status is the low supply event
  assign low_supply_event = !deep_sleep && cmp_settled &&
                            supply_above_threshold && !cmp_above_sync;

  // ---------------------------------------------------------------
  // interrupt status, mask and output
  // ---------------------------------------------------------------
  // write one to clear; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= STM_EVT_RST;
    end else begin
      irq_status <= (irq_status & ~((wr_access && hit_status) ?
                     pwdata[STM_EVT_BIT +: STM_EVT_W] : 1'h0)) | low_supply_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= STM_MASK_RST;
    end else if (wr_access && hit_mask) begin
      irq_mask <= pwdata[STM_EVT_BIT +: STM_EVT_W];
    end
  end

  // level interrupt while an unmasked status bit is set
  assign irq = |(irq_status & irq_mask);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // captured in the setup cycle so it stands through the access phase
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (1'b1)
      hit_ctrl: begin
        next_prdata[STM_CODE_LSB +: STM_CODE_W] = threshold_code;
        next_prdata[STM_RANGE_BIT] = threshold_high_range;
        next_prdata[STM_STATUS_BIT] = supply_above_threshold;
      end
      hit_status: begin
        next_prdata[STM_EVT_BIT +: STM_EVT_W] = irq_status;
      end
      hit_mask: begin
        next_prdata[STM_EVT_BIT +: STM_EVT_W] = irq_mask;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // a fall seen by the event logic, and its recorded effect
  sequence s_fall_seen;
    !deep_sleep && cmp_settled && supply_above_threshold && !cmp_above_sync;
  endsequence

  sequence s_fall_recorded;
    !supply_above_threshold && irq_status[STM_EVT_BIT];
  endsequence

  // a control read captured in the setup cycle
  sequence s_ctrl_read_setup;
    psel && !penable && !pwrite && hit_ctrl;
  endsequence

  property p_status_bit_read;
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_read_setup |=> prdata[STM_STATUS_BIT] == $past(supply_above_threshold);
  endproperty
  a_status_bit_read: assert property (p_status_bit_read)
    else $error("status bit read does not match the supply status");

  property p_status_tracks_cmp;
    @(posedge pclk) disable iff (!presetn)
    !deep_sleep && cmp_settled |=> supply_above_threshold == $past(cmp_above_sync);
  endproperty
  a_status_tracks_cmp: assert property (p_status_tracks_cmp)
    else $error("status does not follow the comparator while awake");

  property p_ctrl_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_access && hit_ctrl) |=>
      threshold_code == $past(pwdata[3:0]) && threshold_high_range == $past(pwdata[4])
      ##1 threshold_mv == $past(next_threshold_mv);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not taken into the threshold settings");

  property p_high_ladder;
    @(posedge pclk) disable iff (!presetn)
    threshold_high_range |=>
      threshold_mv == 12'(12'd2550 + 12'd75 * {8'h00, $past(threshold_code)});
  endproperty
  a_high_ladder: assert property (p_high_ladder)
    else $error("high range threshold value wrong");

  property p_low_ladder;
    @(posedge pclk) disable iff (!presetn)
    !threshold_high_range |=>
      threshold_mv == 12'(12'd1700 + 12'd50 * {8'h00, $past(threshold_code)});
  endproperty
  a_low_ladder: assert property (p_low_ladder)
    else $error("low range threshold value wrong");

  property p_event_on_fall;
    @(posedge pclk) disable iff (!presetn)
    s_fall_seen |=> s_fall_recorded;
  endproperty
  a_event_on_fall: assert property (p_event_on_fall)
    else $error("status fall did not raise the low supply event");

  property p_event_needs_fall;
    @(posedge pclk) disable iff (!presetn)
    $rose(irq_status[STM_EVT_BIT]) |-> $past(supply_above_threshold) && !supply_above_threshold;
  endproperty
  a_event_needs_fall: assert property (p_event_needs_fall)
    else $error("low supply event raised without a status fall");

  property p_sleep_freeze;
    @(posedge pclk) disable iff (!presetn)
    deep_sleep |=> $stable(supply_above_threshold) && !$rose(irq_status[STM_EVT_BIT]);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze)
    else $error("monitor active during deepest power-down");

  property p_unsettled_hold;
    @(posedge pclk) disable iff (!presetn)
    !cmp_settled |=> $stable(supply_above_threshold) && !$rose(irq_status[STM_EVT_BIT]);
  endproperty
  a_unsettled_hold: assert property (p_unsettled_hold)
    else $error("status moved on a sample from an unpowered comparator");

  property p_sync_depth;
    @(posedge pclk) disable iff (!presetn)
    (!deep_sleep && cmp_settled) [*3] |-> supply_above_threshold == $past(cmp_above_raw, 3);
  endproperty
  a_sync_depth: assert property (p_sync_depth)
    else $error("comparator level reached status without two flip-flops");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    irq == (irq_status[STM_EVT_BIT] && irq_mask[STM_EVT_BIT]);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output does not match masked status");

endmodule : stm_supply_monitor

// ==== inc/stm_pkg.sv ====
// constants shared by the supply threshold monitor register block
package stm_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] STM_ADDR_CTRL = 12'h000;
  localparam logic [11:0] STM_ADDR_IRQ_STATUS = 12'h004;
  localparam logic [11:0] STM_ADDR_IRQ_MASK = 12'h008;

  // ---------------------------------------------------------------
  // field positions of supply_monitor_control
  // ---------------------------------------------------------------
  localparam int STM_CODE_LSB = 0;
  localparam int STM_CODE_W = 4;
  localparam int STM_RANGE_BIT = 4;
  localparam int STM_STATUS_BIT = 5;

  // field position of the interrupt status and mask registers
  localparam int STM_EVT_BIT = 0;
  localparam int STM_EVT_W = 1;

  // ---------------------------------------------------------------
  // reset values: low range, code two, giving 1.80 V
  // ---------------------------------------------------------------
  localparam logic [3:0] STM_CODE_RST = 4'h2;
  localparam logic STM_RANGE_RST = 1'b0;
  localparam logic STM_STATUS_RST = 1'b0;
  localparam logic [0:0] STM_EVT_RST = 1'h0;
  localparam logic [0:0] STM_MASK_RST = 1'h0;

  // ---------------------------------------------------------------
  // threshold ladder in millivolts
  // ---------------------------------------------------------------
  localparam int STM_MV_W = 12;
  localparam logic [11:0] STM_HIGH_BASE_MV = 12'h9f6; // 2550 mV
  localparam logic [11:0] STM_HIGH_STEP_MV = 12'h04b; // 75 mV
  localparam logic [11:0] STM_LOW_BASE_MV = 12'h6a4;  // 1700 mV
  localparam logic [11:0] STM_LOW_STEP_MV = 12'h032;  // 50 mV

endpackage : stm_pkg

// ==== design/stm_sync2.sv ====
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module stm_sync2
  import stm_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // ---------------------------------------------------------------
  // first stage is read only by the second stage
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : stm_sync2

// ==== design/stm_threshold_decode.sv ====
// maps range select and threshold code to a threshold in millivolts
`timescale 1ns/1ps
module stm_threshold_decode
  import stm_pkg::*;
(
  // threshold selection
  input wire logic [3:0] threshold_code,
  input wire logic threshold_high_range,
  // selected threshold
  output logic [11:0] threshold_mv
);

  logic [11:0] code_ext;

  // ---------------------------------------------------------------
  // linear ascending ladder for each range
  // ---------------------------------------------------------------
  assign code_ext = {8'h00, threshold_code};

  always_comb begin
    if (threshold_high_range) begin
      threshold_mv = STM_HIGH_BASE_MV + code_ext * STM_HIGH_STEP_MV;
    end else begin
      threshold_mv = STM_LOW_BASE_MV + code_ext * STM_LOW_STEP_MV;
    end
  end

endmodule : stm_threshold_decode

// ==== verification/stm_cmp_model.sv ====
// behavioural model of the analogue supply comparator beside the monitor
`timescale 1ns/1ps
module stm_cmp_model
  import stm_pkg::*;
(
  // threshold and enable from the monitor
  input wire logic [11:0] threshold_mv,
  input wire logic monitor_enable,
  // supply level on the external supply pin, in millivolts
  input wire logic [11:0] supply_mv,
  // comparator decision
  output logic cmp_above_raw
);
  // ------------------------------------------------------------
  // comparison
  // ------------------------------------------------------------
  // compares against whatever threshold is presented now; a disabled
  // comparator output is pulled down, so it never reads as above
  assign cmp_above_raw = monitor_enable ? (supply_mv > threshold_mv) : 1'b0;
endmodule : stm_cmp_model

// ==== verification/stm_supply_monitor_tb.sv ====
// self-checking testbench of the supply threshold monitor
`timescale 1ns/1ps
module stm_supply_monitor_tb;
  import stm_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic deep_sleep = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [11:0] supply_mv = 12'h6d6; // 1750 mV, below the reset threshold
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [11:0] threshold_mv;
  logic [3:0] threshold_code;
  logic pready, pslverr, err, cmp_above_raw, monitor_enable, irq, threshold_high_range;
  int bad_count = 0;
  int num_checks = 0;

  // clock generator
  always #12.5 pclk = ~pclk;

  // ------------------------------------------------------------
  // design and comparator model
  // ------------------------------------------------------------
  stm_supply_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_above_raw(cmp_above_raw), .threshold_code(threshold_code),
    .threshold_high_range(threshold_high_range), .threshold_mv(threshold_mv),
    .monitor_enable(monitor_enable), .deep_sleep(deep_sleep), .irq(irq));
  stm_cmp_model cmp (.threshold_mv(threshold_mv), .monitor_enable(monitor_enable),
    .supply_mv(supply_mv), .cmp_above_raw(cmp_above_raw));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // compares and counts, reporting a mismatch at once
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk

  // moves the supply and lets the synchroniser settle
  task automatic settle(input logic [11:0] mv);
    @(posedge pclk);
    supply_mv <= mv;
    repeat (6) @(posedge pclk);
  endtask : settle

  // threshold ladder expected for range bit and code
  function automatic logic [31:0] exp_mv(input logic [4:0] s);
    return s[4] ? 32'd2550 + 32'd75 * s[3:0] : 32'd1700 + 32'd50 * s[3:0];
  endfunction : exp_mv

  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rdchk("ctrl_reset", STM_ADDR_CTRL, 32'h02);
    rdchk("evt_never_above", STM_ADDR_IRQ_STATUS, 32'h0);
    chk("irq_reset", 32'h0, {31'h0, irq});
    // sweep all 32 settings, also poking the unused bits above bit 5
    settle(12'hfa0);
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, STM_ADDR_CTRL, 32'hffff_ffc0 | 32'(i));
      repeat (5) @(posedge pclk);
      chk("threshold_mv", exp_mv(5'(i)), {20'h0, threshold_mv});
      chk("thr_fields", 32'(i), {27'h0, threshold_high_range, threshold_code});
      rdchk("ctrl_rw", STM_ADDR_CTRL, 32'h20 | 32'(i));
    end
    rdchk("evt_rise_only", STM_ADDR_IRQ_STATUS, 32'h0);
    // supply fall with the event unmasked
    apb(1'b1, STM_ADDR_IRQ_MASK, 32'h1);
    apb(1'b1, STM_ADDR_CTRL, 32'h02);
    settle(12'h7d0);
    @(posedge pclk);
    supply_mv <= 12'h6d6;
    repeat (2) @(posedge pclk);
    #1 chk("irq_sync_delay", 32'h0, {31'h0, irq});
    @(posedge pclk);
    #1 chk("irq_on_fall", 32'h1, {31'h0, irq});
    rdchk("ctrl_below", STM_ADDR_CTRL, 32'h02);
    rdchk("evt_set", STM_ADDR_IRQ_STATUS, 32'h1);
    apb(1'b1, STM_ADDR_IRQ_STATUS, 32'h1);
    @(posedge pclk);
    #1 chk("irq_cleared", 32'h0, {31'h0, irq});
    // masked fall: sticky bit set, line stays low
    apb(1'b1, STM_ADDR_IRQ_MASK, 32'h0);
    settle(12'h7d0);
    settle(12'h6d6);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdchk("evt_masked", STM_ADDR_IRQ_STATUS, 32'h1);
    apb(1'b1, STM_ADDR_IRQ_STATUS, 32'h1);
    // raising the threshold above the supply compares against the new setting
    apb(1'b1, STM_ADDR_IRQ_MASK, 32'h1);
    settle(12'h7d0);
    apb(1'b1, STM_ADDR_CTRL, 32'h1f);
    repeat (6) @(posedge pclk);
    rdchk("ctrl_new_thr", STM_ADDR_CTRL, 32'h1f);
    rdchk("evt_new_thr", STM_ADDR_IRQ_STATUS, 32'h1);
    apb(1'b1, STM_ADDR_IRQ_STATUS, 32'h1);
    // deepest power-down freezes status and events, wake resumes them
    apb(1'b1, STM_ADDR_CTRL, 32'h02);
    repeat (6) @(posedge pclk);
    // a sleep with the supply still above must not look like a fall on wake
    @(posedge pclk);
    deep_sleep <= 1'b1;
    repeat (6) @(posedge pclk);
    deep_sleep <= 1'b0;
    repeat (8) @(posedge pclk);
    rdchk("evt_wake_above", STM_ADDR_IRQ_STATUS, 32'h0);
    rdchk("ctrl_wake_above", STM_ADDR_CTRL, 32'h22);
    @(posedge pclk);
    deep_sleep <= 1'b1;
    settle(12'h6d6);
    repeat (4) @(posedge pclk);
    rdchk("ctrl_frozen", STM_ADDR_CTRL, 32'h22);
    rdchk("evt_frozen", STM_ADDR_IRQ_STATUS, 32'h0);
    chk("enable_asleep", 32'h0, {31'h0, monitor_enable});
    @(posedge pclk);
    deep_sleep <= 1'b0;
    repeat (8) @(posedge pclk);
    rdchk("evt_on_wake", STM_ADDR_IRQ_STATUS, 32'h1);
    chk("enable_awake", 32'h1, {31'h0, monitor_enable});
    // unmapped address reads zero with an error
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_data", 32'h0, rd);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("ready", 32'h1, {31'h0, pready});
    give_verdict();
  end

  // watchdog at 20000 cycles, well beyond the several hundred cycles the tests take
  initial begin
    #(25 * 20000);
    bad_count++;
    give_verdict();
  end
endmodule : stm_supply_monitor_tb
